//--- core/operation_status_tree.sv
/*
  Operation status tree: top register, instrument summary, four channel
  registers, host command port with one-cycle answers.
  Assumes channel flags arrive asynchronously from the supply stages.
*/
`timescale 1ns/1ps
`default_nettype none
`include "operation_status_tree_map.svh"

module operation_status_tree
  import operation_status_tree_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire cmd_t i_cmd,
  input wire chan_flags_t [3:0] i_chan_flags,
  output var rsp_t o_rsp,
  output logic o_status_oper
);

  // ****************************************************
  // Declarations
  // ****************************************************
  tree_state_t s_reg;
  tree_state_t s_next;
  node_view_t top_v;
  node_view_t inst_v;
  node_view_t [3:0] chan_v;
  node_ctl_t top_ctl;
  node_ctl_t inst_ctl;
  node_ctl_t [3:0] chan_ctl;
  logic [15:0] top_live_state_view;
  logic [15:0] inst_live_state_view;
  logic [15:0] chan_live_state_view [4];
  logic [3:0] chan_sum;
  logic [1:0] chan_idx;
  logic bad_chan;
  logic bad_view;
  logic [15:0] rd_data;
  node_ctl_t cmd_ctl;

  // Turn one command into strobes for a register set
  function automatic node_ctl_t make_ctl(input cmd_t c);
    node_ctl_t k;
    k = '0;
    k.wdata = c.wdata;
    if (c.write) begin
      k.wr_enable = (c.view == VIEW_ENABLE);
      k.wr_ptr = (c.view == VIEW_PTR);
      k.wr_ntr = (c.view == VIEW_NTR);
    end else begin
      // Only the event view clears; condition reads stay passive
      k.rd_clr = (c.view == VIEW_EVENT);
    end
    return k;
  endfunction

  // Pick the view that a read asks for
  function automatic logic [15:0] pick(input node_view_t v, input view_t w);
    logic [15:0] d;
    d = 16'h0;
    case (w)
      VIEW_EVENT: d = v.event_bits;
      VIEW_LIVE_STATE_VIEW: d = v.live_state_view;
      VIEW_ENABLE: d = v.summary_mask;
      VIEW_PTR: d = v.rising_edge_filter;
      VIEW_NTR: d = v.falling_edge_filter;
      default: d = 16'h0;
    endcase
    return d;
  endfunction

  // ****************************************************
  // Channel register sets
  // ****************************************************
  for (genvar g = 0; g < `OST_NUM_CHAN; g++) begin : g_chan
    // Map the synchronised flags onto their bit positions
    always_comb begin
      chan_live_state_view[g] = 16'h0;
      chan_live_state_view[g][`OST_BIT_WAIT] = s_reg.sync2[g].trigger_wait_flag;
      chan_live_state_view[g][`OST_BIT_CV] = s_reg.sync2[g].constant_voltage_flag;
      chan_live_state_view[g][`OST_BIT_OUT] = s_reg.sync2[g].output_on_flag;
      chan_live_state_view[g][`OST_BIT_CC] = s_reg.sync2[g].constant_current_flag;
      chan_live_state_view[g][`OST_BIT_DELAY] = s_reg.sync2[g].output_delay_active;
    end

    status_node #(
      .USED(`OST_CHAN_USED)
    ) u_chan (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_live_state_view(chan_live_state_view[g]),
      .i_ctl(chan_ctl[g]),
      .o_view(chan_v[g])
    );

    assign chan_sum[g] = chan_v[g].summary;
  end

  // ****************************************************
  // Instrument summary and top register sets
  // ****************************************************
  // Channel n lands on summary bit n-1
  assign inst_live_state_view = {12'h0, chan_sum};

  status_node #(
    .USED(`OST_INST_USED)
  ) u_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_live_state_view(inst_live_state_view),
    .i_ctl(inst_ctl),
    .o_view(inst_v)
  );

  // The instrument summary is the only live top condition here
  always_comb begin
    top_live_state_view = 16'h0;
    top_live_state_view[`OST_BIT_INST] = inst_v.summary;
  end

  status_node #(
    .USED(`OST_TOP_USED)
  ) u_top (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_live_state_view(top_live_state_view),
    .i_ctl(top_ctl),
    .o_view(top_v)
  );

  // ****************************************************
  // Command decode
  // ****************************************************
  // Steer strobes to one register set; bad index touches nothing
  always_comb begin
    cmd_ctl = make_ctl(i_cmd);
    chan_idx = 2'(i_cmd.chan - `OST_CHAN_MIN);
    bad_chan = (i_cmd.chan < `OST_CHAN_MIN) || (i_cmd.chan > `OST_CHAN_MAX);
    bad_view = i_cmd.write && ((i_cmd.view == VIEW_EVENT) || (i_cmd.view == VIEW_LIVE_STATE_VIEW));
    top_ctl = '0;
    inst_ctl = '0;
    chan_ctl = '0;
    rd_data = 16'h0;
    if (!i_cmd_valid) begin
      rd_data = 16'h0;
    end else if (i_cmd.level == LVL_TOP) begin
      top_ctl = cmd_ctl;
      rd_data = pick(top_v, i_cmd.view);
    end else if (i_cmd.level == LVL_INST) begin
      inst_ctl = cmd_ctl;
      rd_data = pick(inst_v, i_cmd.view);
    end else if (i_cmd.level == LVL_CHAN && !bad_chan) begin
      chan_ctl[chan_idx] = cmd_ctl;
      rd_data = pick(chan_v[chan_idx], i_cmd.view);
    end else begin
      rd_data = 16'h0;
    end
    // Reads answer with the value before any clear takes effect
    if (i_cmd.write) begin
      rd_data = 16'h0;
    end
  end

  // ****************************************************
  // State
  // ****************************************************
  // Two flops on every flag; the first is read only by the second
  always_comb begin
    s_next = s_reg;
    s_next.sync1 = i_chan_flags;
    s_next.sync2 = s_reg.sync1;
    s_next.rsp.valid = i_cmd_valid;
    if (i_cmd_valid) begin
      s_next.rsp.err = bad_view || (i_cmd.level == LVL_CHAN && bad_chan)
        || (i_cmd.level != LVL_TOP && i_cmd.level != LVL_INST && i_cmd.level != LVL_CHAN);
      s_next.rsp.data = rd_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rsp = s_reg.rsp;
  // Straight from the top set's summary flop
  assign o_status_oper = top_v.summary;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic take_rd;
  assign take_rd = i_cmd_valid && !i_cmd.write;

  sequence s_top_event_read;
    take_rd && i_cmd.level == LVL_TOP && i_cmd.view == VIEW_EVENT;
  endsequence

  property p_top_read;
    s_top_event_read |=> o_rsp.valid && (o_rsp.data == $past(top_v.event_bits));
  endproperty
  a_top_read: assert property (p_top_read)
    else $error("top event read answered wrong");

  property p_top_clear;
    s_top_event_read |-> top_ctl.rd_clr;
  endproperty
  a_top_clear: assert property (p_top_clear)
    else $error("top event read did not clear");

  property p_live_state_view_passive;
    (take_rd && i_cmd.view == VIEW_LIVE_STATE_VIEW) |-> !top_ctl.rd_clr && !inst_ctl.rd_clr
      && (chan_ctl == '0);
  endproperty
  a_live_state_view_passive: assert property (p_live_state_view_passive)
    else $error("condition read disturbed state");

  property p_mask_readback;
    (i_cmd_valid && i_cmd.write && i_cmd.level == LVL_TOP && i_cmd.view == VIEW_ENABLE)
      ##1 !i_cmd_valid ##1 (take_rd && i_cmd.level == LVL_TOP && i_cmd.view == VIEW_ENABLE)
      |=> o_rsp.data == $past(i_cmd.wdata, 3);
  endproperty
  a_mask_readback: assert property (p_mask_readback)
    else $error("mask readback wrong");

  property p_inst_to_top;
    inst_v.summary |=> top_v.live_state_view[`OST_BIT_INST];
  endproperty
  a_inst_to_top: assert property (p_inst_to_top)
    else $error("summary missing from top bit");

  property p_chan_to_inst;
    1'b1 |=> inst_v.live_state_view[3:0] == $past(chan_sum);
  endproperty
  a_chan_to_inst: assert property (p_chan_to_inst)
    else $error("channel summary misrouted");

  property p_bad_chan;
    (i_cmd_valid && i_cmd.level == LVL_CHAN && bad_chan) |-> (chan_ctl == '0) ##1 o_rsp.err;
  endproperty
  a_bad_chan: assert property (p_bad_chan)
    else $error("bad channel index not refused");

  property p_cv_path;
    s_reg.sync2[0].constant_voltage_flag |=> chan_v[0].live_state_view[`OST_BIT_CV];
  endproperty
  a_cv_path: assert property (p_cv_path)
    else $error("voltage flag not on bit 8");

  property p_delay_path;
    $rose(i_chan_flags[1].output_delay_active) ##1 i_chan_flags[1].output_delay_active [*3]
      |=> chan_v[1].live_state_view[`OST_BIT_DELAY];
  endproperty
  a_delay_path: assert property (p_delay_path)
    else $error("delay flag not on bit 12");

  property p_status_bit;
    o_status_oper == |(top_v.event_bits & top_v.summary_mask);
  endproperty
  a_status_bit: assert property (p_status_bit)
    else $error("status byte bit wrong");

endmodule // operation_status_tree

`default_nettype wire

//--- core/operation_status_tree_map.svh
/*
  Offsets, field positions, reset values and counts of the operation
  status tree. Assumes inclusion by bare name from the package.
*/
`ifndef OPERATION_STATUS_TREE_MAP_SVH
`define OPERATION_STATUS_TREE_MAP_SVH

// Register width and channel count
`define OST_WIDTH 16
`define OST_NUM_CHAN 4
`define OST_CHAN_MIN 3'h1
`define OST_CHAN_MAX 3'h4

// Per-channel condition bit positions
`define OST_BIT_WAIT 5
`define OST_BIT_CV 8
`define OST_BIT_OUT 9
`define OST_BIT_CC 10
`define OST_BIT_DELAY 12

// Top register bit fed by the instrument summary
`define OST_BIT_INST 13

// Bits that exist at each level; all others, bit 15 included, read zero in the condition and event views
`define OST_CHAN_USED 16'h1720
`define OST_INST_USED 16'h000f
`define OST_TOP_USED 16'h2000

// Reset values of the host-writable registers
`define OST_ENABLE_RST 16'h0000
`define OST_PTR_RST 16'hffff
`define OST_NTR_RST 16'h0000

`endif

//--- core/operation_status_tree_pkg.sv
/*
  Types of the operation status tree: command, answer, flags, node state.
  Assumes the map header sits beside it.
*/
`include "operation_status_tree_map.svh"

package operation_status_tree_pkg;

  // Level of the tree that a command addresses
  typedef enum logic [1:0] {
    LVL_TOP = 2'h0,
    LVL_INST = 2'h1,
    LVL_CHAN = 2'h2
  } level_t;

  // View of one register set
  typedef enum logic [2:0] {
    VIEW_EVENT = 3'h0,
    VIEW_LIVE_STATE_VIEW = 3'h1,
    VIEW_ENABLE = 3'h2,
    VIEW_PTR = 3'h3,
    VIEW_NTR = 3'h4
  } view_t;

  typedef struct packed {
    logic write;
    level_t level;
    view_t view;
    logic [2:0] chan;
    logic [15:0] wdata;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] data;
  } rsp_t;

  typedef struct packed {
    logic trigger_wait_flag;
    logic constant_voltage_flag;
    logic constant_current_flag;
    logic output_on_flag;
    logic output_delay_active;
  } chan_flags_t;

  typedef struct packed {
    logic wr_enable;
    logic wr_ptr;
    logic wr_ntr;
    logic rd_clr;
    logic [15:0] wdata;
  } node_ctl_t;

  // Whole state of one register set; also its read view
  typedef struct packed {
    logic [15:0] live_state_view;
    logic [15:0] event_bits;
    logic [15:0] summary_mask;
    logic [15:0] rising_edge_filter;
    logic [15:0] falling_edge_filter;
    logic summary;
  } node_view_t;

  typedef struct packed {
    chan_flags_t [3:0] sync1;
    chan_flags_t [3:0] sync2;
    rsp_t rsp;
  } tree_state_t;

endpackage

//--- core/status_node.sv
/*
  One status register set: condition, sticky event, mask, two filters.
  Assumes conditions come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "operation_status_tree_map.svh"

module status_node
  import operation_status_tree_pkg::*;
#(
  parameter logic [15:0] USED = 16'hffff
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_live_state_view,
  input wire node_ctl_t i_ctl,
  output var node_view_t o_view
);

  node_view_t s_reg;
  node_view_t s_next;
  logic [15:0] set_bits;

  // Edges selected by the filters latch events
  always_comb begin
    s_next = s_reg;
    s_next.live_state_view = i_live_state_view & USED;
    set_bits = ((s_next.live_state_view & ~s_reg.live_state_view & s_reg.rising_edge_filter)
      | (~s_next.live_state_view & s_reg.live_state_view & s_reg.falling_edge_filter));
    // A new edge in the read cycle survives the clear
    s_next.event_bits = ((i_ctl.rd_clr ? 16'h0 : s_reg.event_bits) | set_bits) & USED;
    if (i_ctl.wr_enable) begin
      s_next.summary_mask = i_ctl.wdata;
    end
    if (i_ctl.wr_ptr) begin
      s_next.rising_edge_filter = i_ctl.wdata;
    end
    if (i_ctl.wr_ntr) begin
      s_next.falling_edge_filter = i_ctl.wdata;
    end
    s_next.summary = |(s_next.event_bits & s_next.summary_mask);
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_reg <= '{16'h0, 16'h0, `OST_ENABLE_RST, `OST_PTR_RST, `OST_NTR_RST, 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_view = s_reg;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_summary_tracks;
    s_reg.summary == |(s_reg.event_bits & s_reg.summary_mask);
  endproperty
  a_summary_tracks: assert property (p_summary_tracks)
    else $error("summary differs from masked events");

  property p_unused_zero;
    ((s_reg.event_bits | s_reg.live_state_view) & ~USED) == 16'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bit is set");

  property p_sticky;
    !i_ctl.rd_clr |=> (($past(s_reg.event_bits) & ~s_reg.event_bits) == 16'h0);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event bit dropped without read");

  property p_edge_latches;
    (set_bits != 16'h0) |=> ((s_reg.event_bits & $past(set_bits)) == $past(set_bits));
  endproperty
  a_edge_latches: assert property (p_edge_latches)
    else $error("filtered edge not latched");

  property p_read_clears;
    i_ctl.rd_clr |=> ((s_reg.event_bits & ~$past(set_bits)) == 16'h0);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("event read did not clear");

  property p_mask_write;
    i_ctl.wr_enable |=> (s_reg.summary_mask == $past(i_ctl.wdata));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write lost");

endmodule // status_node

`default_nettype wire

//--- dv/operation_status_tree_tb.sv
/*
  Self-checking bench of the operation status tree.
  Assumes the host model beside it and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none

module operation_status_tree_tb
  import operation_status_tree_pkg::*;
;
  logic clk;
  logic rst;
  logic cmd_valid;
  logic status_oper;
  cmd_t cmd;
  rsp_t rsp;
  chan_flags_t [3:0] flags;
  int errors = 0;
  int total_checks = 0;

  operation_status_tree operation_status_tree_i (.i_clk(clk), .i_rst(rst),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_chan_flags(flags), .o_rsp(rsp),
    .o_status_oper(status_oper));
  status_host status_host_i (.i_clk(clk), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
    .i_rsp(rsp));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic complete_run();
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A missing answer ends the run at once
  task automatic req(input logic wr, input level_t lvl, input view_t vw,
      input logic [2:0] ch, input logic [15:0] wd, output rsp_t r);
    bit late;
    status_host_i.xfer(wr, lvl, vw, ch, wd, r, late);
    if (late) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic rd(input string what, input level_t lvl, input view_t vw,
      input logic [2:0] ch, input logic [15:0] exp);
    rsp_t r;
    req(1'b0, lvl, vw, ch, 16'h0000, r);
    chk(what, r.data, exp);
    chk("read err", 16'(r.err), 16'h0000);
  endtask

  task automatic wr(input level_t lvl, input view_t vw, input logic [2:0] ch,
      input logic [15:0] wd);
    rsp_t r;
    req(1'b1, lvl, vw, ch, wd, r);
    chk("write err", 16'(r.err), 16'h0000);
  endtask

  // Index 0 top, 1 instrument, 2..5 channels 1..4
  function automatic level_t lv(input int i);
    return i == 0 ? LVL_TOP : (i == 1 ? LVL_INST : LVL_CHAN);
  endfunction

  // Flag changes need sync, condition and summary stages to settle
  task automatic settle();
    repeat (10) @(negedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Mask and filters of every set: defaults, distinct patterns, then defaults again
  task automatic t_store();
    logic [15:0] d [3];
    d = '{16'h0000, 16'hffff, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      for (int v = 0; v < 3; v++) begin
        rd("reset value", lv(i), view_t'(v + 2), 3'(i - 1), d[v]);
        wr(lv(i), view_t'(v + 2), 3'(i - 1), 16'ha5c3 ^ 16'(i * 7 + v));
      end
    end
    for (int i = 0; i < 6; i++) begin
      for (int v = 0; v < 3; v++) begin
        rd("stored", lv(i), view_t'(v + 2), 3'(i - 1), 16'ha5c3 ^ 16'(i * 7 + v));
        wr(lv(i), view_t'(v + 2), 3'(i - 1), d[v]);
        rd("restored", lv(i), view_t'(v + 2), 3'(i - 1), d[v]);
      end
    end
  endtask

  // Channel bit positions, routing and clear-on-read
  task automatic t_live_state_view();
    flags[0] <= 5'h1f;
    flags[1] <= 5'h09;
    flags[2] <= 5'h04;
    flags[3] <= 5'h10;
    settle();
    rd("ch1 live_state_view", LVL_CHAN, VIEW_LIVE_STATE_VIEW, 3'h1, 16'h1720);
    rd("ch2 live_state_view", LVL_CHAN, VIEW_LIVE_STATE_VIEW, 3'h2, 16'h1100);
    rd("ch3 live_state_view", LVL_CHAN, VIEW_LIVE_STATE_VIEW, 3'h3, 16'h0400);
    rd("ch4 live_state_view", LVL_CHAN, VIEW_LIVE_STATE_VIEW, 3'h4, 16'h0020);
    rd("ch1 live_state_view again", LVL_CHAN, VIEW_LIVE_STATE_VIEW, 3'h1, 16'h1720);
    rd("inst live_state_view unmasked", LVL_INST, VIEW_LIVE_STATE_VIEW, 3'h0, 16'h0000);
    rd("ch1 event", LVL_CHAN, VIEW_EVENT, 3'h1, 16'h1720);
    rd("ch1 event cleared", LVL_CHAN, VIEW_EVENT, 3'h1, 16'h0000);
  endtask

  // Masked channel summaries climb to the status byte bit
  task automatic t_chain();
    wr(LVL_CHAN, VIEW_ENABLE, 3'h2, 16'h0100);
    wr(LVL_CHAN, VIEW_ENABLE, 3'h4, 16'h0020);
    settle();
    rd("inst live_state_view", LVL_INST, VIEW_LIVE_STATE_VIEW, 3'h0, 16'h000a);
    wr(LVL_INST, VIEW_ENABLE, 3'h0, 16'h0002);
    settle();
    rd("top live_state_view", LVL_TOP, VIEW_LIVE_STATE_VIEW, 3'h0, 16'h2000);
    chk("oper bit unmasked", 16'(status_oper), 16'h0000);
    wr(LVL_TOP, VIEW_ENABLE, 3'h0, 16'h2000);
    settle();
    chk("oper bit", 16'(status_oper), 16'h0001);
    rd("top event", LVL_TOP, VIEW_EVENT, 3'h0, 16'h2000);
    rd("top event cleared", LVL_TOP, VIEW_EVENT, 3'h0, 16'h0000);
    chk("oper bit cleared", 16'(status_oper), 16'h0000);
    rd("inst event", LVL_INST, VIEW_EVENT, 3'h0, 16'h000a);
    rd("inst event cleared", LVL_INST, VIEW_EVENT, 3'h0, 16'h0000);
  endtask

  // Falling filter latches a drop; a cleared rising filter ignores a rise
  task automatic t_filters();
    wr(LVL_CHAN, VIEW_PTR, 3'h3, 16'h0000);
    wr(LVL_CHAN, VIEW_NTR, 3'h3, 16'h0400);
    wr(LVL_CHAN, VIEW_PTR, 3'h4, 16'h0000);
    rd("ch3 old event", LVL_CHAN, VIEW_EVENT, 3'h3, 16'h0400);
    flags[2] <= 5'h00;
    flags[3] <= 5'h18;
    settle();
    rd("ch3 fall event", LVL_CHAN, VIEW_EVENT, 3'h3, 16'h0400);
    rd("ch4 rise ignored", LVL_CHAN, VIEW_EVENT, 3'h4, 16'h0020);
    rd("ch4 live_state_view", LVL_CHAN, VIEW_LIVE_STATE_VIEW, 3'h4, 16'h0120);
  endtask

  // Bad channel index and writes to read-only views
  task automatic t_refuse();
    rsp_t r;
    req(1'b0, LVL_CHAN, VIEW_LIVE_STATE_VIEW, 3'h0, 16'h0000, r);
    chk("chan 0 err", 16'(r.err), 16'h0001);
    chk("chan 0 data", r.data, 16'h0000);
    req(1'b0, LVL_CHAN, VIEW_LIVE_STATE_VIEW, 3'h5, 16'h0000, r);
    chk("chan 5 err", 16'(r.err), 16'h0001);
    req(1'b1, LVL_CHAN, VIEW_EVENT, 3'h4, 16'hffff, r);
    chk("event write err", 16'(r.err), 16'h0001);
    rd("ch4 event kept", LVL_CHAN, VIEW_EVENT, 3'h4, 16'h0000);
    req(1'b0, level_t'(2'h3), VIEW_LIVE_STATE_VIEW, 3'h0, 16'h0000, r);
    chk("level 3 err", 16'(r.err), 16'h0001);
    req(1'b1, LVL_TOP, VIEW_LIVE_STATE_VIEW, 3'h0, 16'hffff, r);
    chk("live_state_view write err", 16'(r.err), 16'h0001);
    rd("top live_state_view kept", LVL_TOP, VIEW_LIVE_STATE_VIEW, 3'h0, 16'h0000);
  endtask

  // Mid-run reset brings back defaults; standing flags latch afresh
  task automatic t_reset();
    rst <= 1'b1;
    repeat (2) @(negedge clk);
    rst <= 1'b0;
    rd("top mask reset", LVL_TOP, VIEW_ENABLE, 3'h0, 16'h0000);
    rd("inst mask reset", LVL_INST, VIEW_ENABLE, 3'h0, 16'h0000);
    rd("ch4 rise reset", LVL_CHAN, VIEW_PTR, 3'h4, 16'hffff);
    rd("ch3 fall reset", LVL_CHAN, VIEW_NTR, 3'h3, 16'h0000);
    settle();
    rd("ch2 live_state_view after reset", LVL_CHAN, VIEW_LIVE_STATE_VIEW, 3'h2, 16'h1100);
    rd("ch1 event after reset", LVL_CHAN, VIEW_EVENT, 3'h1, 16'h1720);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    flags = '0;
    repeat (6) @(negedge clk);
    rst <= 1'b0;
    t_store();
    t_live_state_view();
    t_chain();
    t_filters();
    t_refuse();
    t_reset();
    complete_run();
  end
endmodule // operation_status_tree_tb

`default_nettype wire

//--- dv/status_host.sv
/*
  Host model of the operation status tree: sends one query or set command
  at a time and collects the answer.
  Assumes the tree answers within a few cycles of taking a command.
*/
`timescale 1ns/1ps
`default_nettype none

module status_host
  import operation_status_tree_pkg::*;
(
  input wire logic i_clk,
  output logic o_cmd_valid,
  output cmd_t o_cmd,
  input wire rsp_t i_rsp
);
  // Idle command port at time zero
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
  end

  // One command, raised after a falling edge and held across the taking edge
  task automatic xfer(input logic wr, input level_t lvl, input view_t vw,
      input logic [2:0] ch, input logic [15:0] wd, output rsp_t r, output bit late);
    int n;
    n = 0;
    @(negedge i_clk);
    o_cmd <= '{write: wr, level: lvl, view: vw, chan: ch, wdata: wd};
    o_cmd_valid <= 1'b1;
    @(posedge i_clk);
    @(negedge i_clk);
    o_cmd_valid <= 1'b0;
    // Released fields are inverted so no stale command looks meaningful
    o_cmd <= cmd_t'(~o_cmd);
    while (i_rsp.valid !== 1'b1 && n < 4) begin
      @(negedge i_clk);
      n++;
    end
    r = i_rsp;
    late = (n == 4);
  endtask
endmodule // status_host

`default_nettype wire
